// *** sar_edge_sync.sv ***
// Two-flop synchroniser for one pin with edge pulses derived after it.
// Assumes the pin is asynchronous to i_clk.

`timescale 1ns/1ps
`default_nettype none

module sar_edge_sync #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pin,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);

   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic meta_d;
   logic sync_d;
   logic prev_d;

   // Next values; the first flop feeds only the second
   always_comb begin
      meta_d = i_pin;
      sync_d = meta_q;
      prev_d = sync_q;
   end

   // Register stage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
         prev_q <= RST_VAL;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
         prev_q <= prev_d;
      end
   end

   // Edges look only at the settled stages
   assign o_level = sync_q;
   assign o_rise = sync_q & ~prev_q;
   assign o_fall = ~sync_q & prev_q;

endmodule

`default_nettype wire

// *** sar_master_model.sv ***
// Serial master model: drives frame select and serial clock, captures data.
// Assumes i_clk is the bench clock; the serial clock half period is H cycles.

`timescale 1ns/1ps
`default_nettype none

module sar_master_model #(
   parameter int H = 8
) (
   input wire logic i_clk,
   input wire logic i_sdo,
   input wire logic i_oe,
   input wire logic i_track,
   output logic o_cs_n,
   output logic o_sclk
);
   logic last_q = 1'b0;
   // Released line shows the inverse of the last driven level, never a kind value
   wire logic serial_result_out_line = i_oe ? i_sdo : ~last_q;

   // Last level the device drove
   always @(posedge i_clk) begin
      if (i_oe) begin
         last_q <= i_sdo;
      end
   end

   // Idle with select high and clock high, standing still between frames
   initial begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
   end

   // Wait n clock edges, then step just past the edge
   task automatic wt(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   // One frame of n serial clocks after gap idle cycles
   task automatic frame(input int gap, input int n, output logic [15:0] d, output logic [15:0] e,
                        output logic [16:0] t);
      d = '0;
      e = '0;
      t = '0;
      wt(gap);
      o_cs_n = 1'b0;
      wt(H);
      t[0] = i_track;
      for (int k = 1; k <= n; k++) begin
         o_sclk = 1'b0;
         wt(H);
         d[16-k] = serial_result_out_line;  // Capture on the rise
         e[16-k] = i_oe;
         o_sclk = 1'b1;
         wt(H);
         t[k] = i_track;
      end
      o_cs_n = 1'b1;
      wt(H);
   endtask

   // Park the serial clock at a level while select stays high
   task automatic park(input logic lvl);
      o_sclk = lvl;
      wt(H);
   endtask
endmodule

`default_nettype wire

// *** sar_pkg.sv ***
// Constants, state encoding and timing counts for the serial readout of an
// 8-bit successive-approximation converter.
// Assumes a 200 MHz system clock that samples the frame select and serial clock pins.

package sar_pkg;

   // ********************************************************************
   // Result and frame layout
   // ********************************************************************
   localparam int SAR_RES_BITS = 8;
   localparam logic [4:0] SAR_FIRST_DATA_FALL = 5'h03;  // Fall that drives the MSB
   localparam logic [4:0] SAR_LAST_DATA_FALL = 5'h0A;   // Fall that drives the LSB
   localparam logic [4:0] SAR_LAST_STEP_RISE = 5'h08;   // Rise that decides the LSB
   localparam logic [4:0] SAR_TRACK_RISE = 5'h0D;       // Hold ends on this rise
   localparam logic [4:0] SAR_TRISTATE_FALL = 5'h10;    // Output released after this fall
   localparam logic [4:0] SAR_SHDN_LO_FALL = 5'h02;     // Shutdown window opens
   localparam logic [4:0] SAR_SHDN_HI_FALL = 5'h0A;     // Shutdown window closes
   localparam logic [4:0] SAR_CNT_MAX = 5'h1F;
   localparam logic [7:0] SAR_STEP_MSB = 8'h80;

   // ********************************************************************
   // Pin reset values
   // ********************************************************************
   localparam logic SAR_CS_RST = 1'b1;
   localparam logic SAR_SCLK_RST = 1'b0;

   // ********************************************************************
   // Timing
   // ********************************************************************
   localparam int SAR_CLK_PERIOD_PS = 5000;
   localparam int SAR_TRACK_TIME_MIN_NS = 350;  // track_time_min
   localparam int SAR_TRACK_MIN_CYC = (SAR_TRACK_TIME_MIN_NS * 1000 + SAR_CLK_PERIOD_PS - 1) / SAR_CLK_PERIOD_PS;
   localparam logic [6:0] SAR_TRACK_MIN_CNT = 7'(SAR_TRACK_MIN_CYC);
   localparam logic [6:0] SAR_ACQ_CNT_MAX = 7'h7F;

   // ********************************************************************
   // Converter phase
   // ********************************************************************
   typedef enum logic [1:0] {
      SAR_IDLE = 2'b00,
      SAR_HOLD = 2'b01,
      SAR_TRACK = 2'b11
   } sar_state_e;

endpackage

// *** sar_readout.sv ***
// Frame-select driven conversion and serial readout of an 8-bit SAR converter.
// Assumes i_sample_code is the quantised input on the i_clk domain and the
// serial clock is far slower than i_clk, so every pin edge is seen once.
//
// Contract
// [RQ1] Frame select falling starts a conversion and a frame lasting until it rises.
// [RQ2] Serial clock edges are counted from the latest frame select fall, from one.
// [RQ3] On frame select fall the output is driven and the input is held.
// [RQ4] Hold ends and tracking resumes on the 13th rising serial clock edge.
// [RQ5] Controller leaves at least 350 ns from 13th rise to next frame.
// [RQ6] Output released after the 16th falling edge or frame select rise.
// [RQ7] Controller waits the quiet gap before starting the next conversion.
// [RQ8] Controller supplies sixteen serial clocks to read a full sample.
// [RQ9] Bits change on falling edges and are captured on following rising edges.
// [RQ10] Frame is three zeros, eight result bits MSB first, then zeros.
// [RQ11] Select falling with clock low may yield one extra leading zero.
// [RQ12] Controller spaces frames by hold, track and alignment padding.
// [RQ13] Twenty-clock frames give best throughput; shorter frames allowed within limits.
// [RQ14] Result is unsigned straight binary, zero input gives zero code.
// [RQ15] Codes step at half an LSB then every LSB of supply over 256.
// [RQ16] Serial clock sequences both approximation steps and output shifting.
// [RQ17] Select rise between falls two and ten aborts and enters shutdown.
// [RQ18] Select rise between falls ten and sixteen aborts, truncates, stays normal.
// [RQ19] Select rise before the second fall leaves the mode unchanged.
// [RQ20] First conversion after shutdown is flagged invalid; controller discards it.
// [RQ21] Falling-edge counter clears while select is high and steers decisions.

`timescale 1ns/1ps
`default_nettype none

module sar_readout
   import sar_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic [7:0] i_sample_code,
   output logic o_serial_result_out,
   output logic o_serial_result_oe,
   output logic o_track,
   output logic o_shutdown,
   output logic o_first_invalid,
   output logic o_track_short
);

   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   logic cs_lvl;
   logic cs_rise;
   logic cs_fall;
   logic sclk_rise;
   logic sclk_fall;

   sar_edge_sync #(.RST_VAL(SAR_CS_RST)) u_cs_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_cs_n),
      .o_level(cs_lvl),
      .o_rise(cs_rise),
      .o_fall(cs_fall)
   );

   sar_edge_sync #(.RST_VAL(SAR_SCLK_RST)) u_sclk_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_sclk),
      .o_level(),
      .o_rise(sclk_rise),
      .o_fall(sclk_fall)
   );

   // ********************************************************************
   // Conversion state
   // ********************************************************************
   sar_state_e state_q, state_d;
   logic [4:0] fcnt_q, fcnt_d;
   logic [4:0] rcnt_q, rcnt_d;
   logic [7:0] held_q, held_d;
   logic [7:0] sar_q, sar_d;
   logic [7:0] trial;
   logic data_q, data_d;
   logic oe_q, oe_d;
   logic track_q, track_d;
   logic shut_q, shut_d;
   logic mode_start_q, mode_start_d;
   logic inv_q, inv_d;
   logic [6:0] acq_q, acq_d;
   logic short_q, short_d;
   logic in_frame;
   logic [4:0] fnext;

   assign in_frame = ~cs_lvl;
   assign fnext = (fcnt_q == SAR_CNT_MAX) ? fcnt_q : fcnt_q + 5'h01;
   // Trial adds the bit that this rise decides
   assign trial = sar_q | (SAR_STEP_MSB >> (rcnt_q[2:0]));

   // Next-state logic; select edges take priority over clock edges
   always_comb begin
      state_d = state_q;
      fcnt_d = fcnt_q;
      rcnt_d = rcnt_q;
      held_d = held_q;
      sar_d = sar_q;
      data_d = data_q;
      oe_d = oe_q;
      shut_d = shut_q;
      mode_start_d = mode_start_q;
      inv_d = inv_q;
      acq_d = (acq_q == SAR_ACQ_CNT_MAX) ? acq_q : acq_q + 7'h01;
      short_d = short_q;
      if (cs_fall) begin
         // New conversion: hold the input, drive the line, power up [RQ1] [RQ3]
         state_d = SAR_HOLD;
         fcnt_d = 5'h00;                                  // [RQ2]
         rcnt_d = 5'h00;
         held_d = i_sample_code;                          // Straight binary code [RQ14] [RQ15]
         sar_d = 8'h00;
         oe_d = 1'b1;                                     // [RQ3]
         data_d = 1'b0;                                   // Clock low here gives an extra zero [RQ11]
         mode_start_d = shut_q;
         shut_d = 1'b0;
         inv_d = shut_q;                                  // Warm-up conversion [RQ20]
         // Flag a controller that cut the track interval short [RQ5]
         short_d = (state_q != SAR_HOLD) && (acq_q < SAR_TRACK_MIN_CNT);
      end else if (cs_rise) begin
         // Frame ends; output released at once [RQ6]
         oe_d = 1'b0;
         data_d = 1'b0;
         fcnt_d = 5'h00;                                  // [RQ21]
         rcnt_d = 5'h00;
         state_d = SAR_IDLE;
         if (state_q == SAR_HOLD) begin
            acq_d = 7'h00;                                // Aborted hold starts tracking now
         end
         if (fcnt_q < SAR_SHDN_LO_FALL) begin
            shut_d = mode_start_q;                        // Noise guard [RQ19] [RQ21]
         end else if (fcnt_q < SAR_SHDN_HI_FALL) begin
            shut_d = 1'b1;                                // [RQ17]
         end else begin
            shut_d = 1'b0;                                // Truncated word, normal mode [RQ18]
         end
      end else if (in_frame) begin
         if (sclk_rise) begin
            rcnt_d = (rcnt_q == SAR_CNT_MAX) ? rcnt_q : rcnt_q + 5'h01;
            // One approximation step on each of the first eight rises, MSB first [RQ16]
            if (rcnt_q < SAR_LAST_STEP_RISE) begin
               sar_d = (held_q >= trial) ? trial : sar_q;
            end
            if (rcnt_q == SAR_TRACK_RISE - 5'h01) begin
               state_d = SAR_TRACK;                       // [RQ4]
               acq_d = 7'h00;
            end
         end else if (sclk_fall) begin
            fcnt_d = fnext;                               // [RQ2] [RQ21]
            // Bits change only on falling edges [RQ9] [RQ16]
            if (fnext >= SAR_FIRST_DATA_FALL && fnext <= SAR_LAST_DATA_FALL) begin
               data_d = sar_q[3'(SAR_LAST_DATA_FALL - fnext)]; // [RQ10]
            end else begin
               data_d = 1'b0;                             // Leading and trailing zeros [RQ10]
            end
            if (fnext >= SAR_TRISTATE_FALL) begin
               oe_d = 1'b0;                               // [RQ6]
               data_d = 1'b0;
            end
         end
      end else begin
         // Counters stay clear while select is high [RQ21]
         fcnt_d = 5'h00;
         rcnt_d = 5'h00;
      end
      track_d = (state_d != SAR_HOLD);
   end

   // Register stage
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= SAR_IDLE;
         fcnt_q <= 5'h00;
         rcnt_q <= 5'h00;
         held_q <= 8'h00;
         sar_q <= 8'h00;
         data_q <= 1'b0;
         oe_q <= 1'b0;
         track_q <= 1'b1;
         shut_q <= 1'b0;
         mode_start_q <= 1'b0;
         inv_q <= 1'b0;
         acq_q <= SAR_ACQ_CNT_MAX;
         short_q <= 1'b0;
      end else begin
         state_q <= state_d;
         fcnt_q <= fcnt_d;
         rcnt_q <= rcnt_d;
         held_q <= held_d;
         sar_q <= sar_d;
         data_q <= data_d;
         oe_q <= oe_d;
         track_q <= track_d;
         shut_q <= shut_d;
         mode_start_q <= mode_start_d;
         inv_q <= inv_d;
         acq_q <= acq_d;
         short_q <= short_d;
      end
   end

   // Outputs straight from flops
   assign o_serial_result_out = data_q;
   assign o_serial_result_oe = oe_q;
   assign o_track = track_q;
   assign o_shutdown = shut_q;
   assign o_first_invalid = inv_q;
   assign o_track_short = short_q;

   // ********************************************************************
   // Assertions
   // ********************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_frame_open;
      cs_fall ##1 (oe_q && !data_q);
   endsequence

   sequence s_hold_entered;
      cs_fall ##1 (state_q == SAR_HOLD && !track_q && fcnt_q == 5'h00);
   endsequence

   a_frame_start_hold: assert property (cs_fall |-> s_hold_entered) // [RQ1]
      else $error("Frame start did not enter hold");
   a_drive_on_fall: assert property (cs_fall |-> s_frame_open) // [RQ3]
      else $error("Output not driven at frame start");
   a_held_sample: assert property (cs_fall |=> held_q == $past(i_sample_code)) // [RQ3]
      else $error("Input not captured at frame start");
   a_track_at_13: assert property (in_frame && !cs_fall && !cs_rise && sclk_rise
         && rcnt_q == 5'h0C |=> track_q && state_q == SAR_TRACK) // [RQ4]
      else $error("Tracking did not resume on 13th rise");
   a_release_on_rise: assert property (cs_rise |=> !oe_q) // [RQ6]
      else $error("Output still driven after select rose");
   a_release_at_16: assert property (in_frame && !cs_fall && !cs_rise && sclk_fall
         && fcnt_q == 5'h0F |=> !oe_q && fcnt_q == SAR_TRISTATE_FALL) // [RQ6]
      else $error("Output still driven after 16th fall");
   a_lead_zeros: assert property (in_frame && !cs_fall && !cs_rise && sclk_fall
         && fcnt_q < 5'h02 |=> !data_q) // [RQ10]
      else $error("Leading bit not zero");
   a_data_bits: assert property (in_frame && !cs_fall && !cs_rise && sclk_fall
         && fcnt_q >= 5'h02 && fcnt_q <= 5'h09 && state_q == SAR_HOLD
         |=> data_q == held_q[3'(5'h09 - $past(fcnt_q))]) // [RQ10] [RQ14]
      else $error("Result bit does not match held sample");
   a_count_clear: assert property (cs_lvl && !cs_fall |=> fcnt_q == 5'h00 [*2]) // [RQ21]
      else $error("Fall counter not clear while select high");
   a_enter_shutdown: assert property (cs_rise && fcnt_q >= 5'h02 && fcnt_q <= 5'h09
         |=> shut_q) // [RQ17]
      else $error("Shutdown not entered");
   a_stay_normal: assert property (cs_rise && fcnt_q >= 5'h0A |=> !shut_q) // [RQ18]
      else $error("Mode left normal after late abort");
   a_noise_guard: assert property (cs_rise && fcnt_q < 5'h02 |=> shut_q == $past(mode_start_q)) // [RQ19]
      else $error("Mode changed by short select pulse");
   a_warmup_flag: assert property (cs_fall |=> inv_q == $past(shut_q) && !shut_q) // [RQ20]
      else $error("Warm-up conversion flag wrong");
   // Flag reports a track interval that the controller cut short
   a_short_flag: assert property (cs_fall && state_q == SAR_TRACK && acq_q < SAR_TRACK_MIN_CNT
         |=> short_q) // [RQ5]
      else $error("Short track interval not flagged");

   // ********************************************************************
   // Clock-edge sequencing inside a frame
   // ********************************************************************
   // A serial clock edge that no select edge overrides
   sequence s_mid_rise;
      in_frame && !cs_fall && !cs_rise && sclk_rise;
   endsequence

   sequence s_mid_fall;
      in_frame && !cs_fall && !cs_rise && sclk_fall;
   endsequence

   // Counters step by one per edge; saturation keeps long frames harmless
   a_fall_count: assert property (s_mid_fall ##0 (fcnt_q < SAR_CNT_MAX)
         |=> fcnt_q == $past(fcnt_q) + 5'h01) // [RQ2] [RQ21]
      else $error("Fall counter did not step");
   a_rise_count: assert property (s_mid_rise ##0 (rcnt_q < SAR_CNT_MAX)
         |=> rcnt_q == $past(rcnt_q) + 5'h01) // [RQ2]
      else $error("Rise counter did not step");
   // Eight rises settle the approximation on the held code
   a_sar_done: assert property (s_mid_rise ##0 (rcnt_q == 5'h07) |=> sar_q == held_q) // [RQ14] [RQ16]
      else $error("Approximation did not converge");
   // Falls 11 to 15 pad the word with zeros
   a_trail_zeros: assert property (s_mid_fall ##0 (fcnt_q >= 5'h0A && fcnt_q <= 5'h0E)
         |=> !data_q) // [RQ10]
      else $error("Trailing bit not zero");
   // Enable drops only on fall 16 or on select rise
   a_oe_holds: assert property (oe_q && in_frame && !sclk_fall |=> oe_q) // [RQ6]
      else $error("Output released too early");
   a_oe_stays_off: assert property (!oe_q && !cs_fall |=> !oe_q) // [RQ6] [RQ17]
      else $error("Output driven outside a frame");
   // Released line carries a low level, so no stale bit lingers
   a_idle_low: assert property (!oe_q |-> !data_q) // [RQ6]
      else $error("Data not low while released");

endmodule

`default_nettype wire

// *** tb_sar_readout.sv ***
// Self-checking bench for the serial readout: full, truncated and shutdown frames.
// Assumes sar_master_model drives the pins and the design runs on a 5 ns clock.

`timescale 1ns/1ps
`default_nettype none

module tb_sar_readout;
   import sar_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] code = 8'h00;
   logic cs_n;
   logic sclk;
   logic sdo;
   logic oe;
   logic trk;
   logic sd;
   logic fi;
   logic ts;
   logic [15:0] d;
   logic [15:0] e;
   logic [16:0] t;
   int n_mismatch = 0;
   int cmp_count = 0;

   // ********************************************************************
   // Clock, design and master
   // ********************************************************************
   initial begin
      forever #2.5 clk = ~clk;
   end

   sar_readout u_sar_readout (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_sample_code(code),
      .o_serial_result_out(sdo), .o_serial_result_oe(oe), .o_track(trk), .o_shutdown(sd),
      .o_first_invalid(fi), .o_track_short(ts));

   sar_master_model #(.H(8)) u_sar_master_model (.i_clk(clk), .i_sdo(sdo), .i_oe(oe), .i_track(trk),
      .o_cs_n(cs_n), .o_sclk(sclk));

   // ********************************************************************
   // Comparison and verdict
   // ********************************************************************
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One frame; enable mask covers the rises that see a driven bit
   task automatic frame_chk(input int gap, input int n, input logic [7:0] c, input logic xsd, input logic xfi);
      logic [15:0] m;
      m = ~(16'hFFFF >> n) & 16'hFFFE;
      code = c;
      u_sar_master_model.frame(gap, n, d, e, t);
      check("oe", e, m);
      check("data", d & m, {2'h0, c, 6'h00} & m);
      check("oe_after", 16'(oe), 16'h0000);
      check("track_hold", 16'(t[0]), 16'h0000);
      if (n == 16) begin
         check("track_13", 16'({t[12], t[13]}), 16'h0001);
      end
      check("shutdown", 16'(sd), 16'(xsd));
      check("first_inv", 16'(fi), 16'(xfi));
   endtask

   // ********************************************************************
   // Scenarios
   // ********************************************************************
   // Codes from all-zero to all-one, bit patterns both ways
   task automatic s_codes();
      logic [7:0] tab [6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h01, 8'h80};
      foreach (tab[i]) begin
         frame_chk(80, 16, tab[i], 1'b0, 1'b0);
      end
   endtask

   // Select falls with the clock parked low: one extra leading zero reaches the receiver
   task automatic s_clk_low();
      u_sar_master_model.park(1'b0);
      code = 8'hB7;
      u_sar_master_model.frame(80, 16, d, e, t);
      check("oe_park", e, 16'hFFFF);
      check("data_park", d, {3'h0, 8'hB7, 5'h00});
      check("track_13_park", 16'({t[12], t[13]}), 16'h0001);
      check("oe_after_park", 16'(oe), 16'h0000);
      check("shutdown_park", 16'(sd), 16'h0000);
   endtask

   // Truncation at twelve falls and at the boundary of ten
   task automatic s_trunc();
      frame_chk(80, 12, 8'hC3, 1'b0, 1'b0);
      frame_chk(80, 10, 8'h3C, 1'b0, 1'b0);
   endtask

   // Shutdown entry, noise pulses, dummy conversion on wake
   task automatic s_shut();
      frame_chk(80, 2, 8'h96, 1'b1, 1'b0);
      frame_chk(80, 1, 8'h96, 1'b1, 1'b1);
      frame_chk(80, 9, 8'h69, 1'b1, 1'b1);
      frame_chk(80, 16, 8'h69, 1'b0, 1'b1);
      frame_chk(80, 16, 8'h69, 1'b0, 1'b0);
      frame_chk(80, 1, 8'h11, 1'b0, 1'b0);
   endtask

   // Short track interval flagged, then cleared by a long one
   task automatic s_short();
      frame_chk(80, 16, 8'h42, 1'b0, 1'b0);
      frame_chk(1, 16, 8'h24, 1'b0, 1'b0);
      check("short_set", 16'(ts), 16'h0001);
      frame_chk(30, 16, 8'h18, 1'b0, 1'b0);
      check("short_clr", 16'(ts), 16'h0000);
   endtask

   // Main sequence after 20 cycles of reset
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      s_codes();
      s_clk_low();
      s_trunc();
      s_shut();
      s_short();
      close_out();
   end

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      close_out();
   end
endmodule

`default_nettype wire
